// *** design/uart_abd_pkg.sv ***
// How it works
// - setting autobaud holds receiver idle while calibrating
// - measure a 55h sync with five rises
// - count starts on first rise after start
// - fifth rise: keep count, clear enable, flag
// - reading receive data clears flag; software discards
// - divisor pair is one 16-bit counter
// - counter runs at base clock over eight
// - speed selects pick osc/512, /128 or /32
// - counter starts at one; software subtracts one
// - with wake enabled, measure byte after break
// - wake-on-break only in asynchronous mode
// - wake enabled: receiver held idle, line watched
// - falling receive line is the wake event
// - wake event sets flag; async request in sleep
// - rising edge ending break clears wake enable
// - non-zero char: rest arrives as fragment
// - sleep stops only baud counting; wake detector runs
package uart_abd_pkg;

    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 2'h0;
    localparam logic [ADDR_W-1:0] OFF_DIV_LOW = 2'h1;
    localparam logic [ADDR_W-1:0] OFF_DIV_HIGH = 2'h2;
    localparam logic [ADDR_W-1:0] OFF_RX_DATA = 2'h3;

    // baud_control_reg fields
    localparam int AUTOBAUD_EN_BIT = 0;
    localparam int WAKE_EN_BIT = 1;
    localparam int SYNC_MODE_BIT = 2;
    localparam int DIV16_BIT = 3;
    localparam int HIGH_SPEED_BIT = 4;
    localparam int IDLE_BIT = 6;
    localparam int IRQ_BIT = 7;

    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

    // calibration counter
    localparam int COUNT_W = 16;
    localparam logic [COUNT_W-1:0] COUNT_START = 16'h0001;
    localparam logic [COUNT_W-1:0] COUNT_STEP = 16'h0001;

    // autobaud clock dividers, terminal counts for osc/512, /128, /32
    localparam int PRESCALE_W = 9;
    localparam logic [PRESCALE_W-1:0] DIV_SLOW = 9'h1ff;
    localparam logic [PRESCALE_W-1:0] DIV_MID = 9'h07f;
    localparam logic [PRESCALE_W-1:0] DIV_FAST = 9'h01f;
    localparam logic [PRESCALE_W-1:0] PRESCALE_STEP = 9'h001;

    // rising edges counted before the closing fifth one
    localparam logic [2:0] RISE_LAST = 3'h4;
    localparam logic [2:0] RISE_FIRST = 3'h1;
    localparam logic [2:0] RISE_STEP = 3'h1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic div16;
        logic high_speed;
        logic [COUNT_W-1:0] divisor;
    } baud_cfg_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_AFTER_BREAK = 5'b00010,
        ST_WAIT_START = 5'b00100,
        ST_WAIT_RISE = 5'b01000,
        ST_MEASURE = 5'b10000
    } abd_state_t;

endpackage

// *** design/uart_autobaud_wake.sv ***
`timescale 1ns/10ps
module uart_autobaud_wake
    import uart_abd_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire reg_req_t req,
    output logic [DATA_W-1:0] rdata,
    // serial pin and power state
    input wire logic receive_line,
    input wire logic sleep_mode,
    // normal receiver
    input wire logic receiver_busy,
    input wire logic [DATA_W-1:0] rx_byte,
    input wire logic rx_byte_done,
    output logic receiver_hold,
    // baud generator and wake
    output baud_cfg_t baud_cfg,
    output logic wake_request
);

    generate
        if (CNT_W != COUNT_W) begin : g_bad_width
            $error("divisor pair must be 16 bits");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // receive line synchroniser and edges

    logic rx_meta;
    logic rx_sync;
    logic rx_prev;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= receive_line;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    wire rise = rx_sync & ~rx_prev;
    wire fall = ~rx_sync & rx_prev;
    // sleep halts only the autobaud sequencer; registers, flags and the wake detector keep going
    wire run = ~sleep_mode;

    ////////////////////////////////////////////////////////////////////////////////
    // register decode

    logic autobaud_enable;
    logic wake_on_break_enable;
    logic sync_mode;
    logic divisor_16bit_select;
    logic high_speed_select;
    logic receive_irq_flag;
    logic [DATA_W-1:0] divisor_low;
    logic [DATA_W-1:0] divisor_high;
    logic [DATA_W-1:0] receive_data_reg;
    abd_state_t state;
    abd_state_t next_state;
    logic [PRESCALE_W-1:0] prescale;
    logic [2:0] rises;

    wire sel_ctl = req.addr == OFF_CONTROL;
    wire sel_low = req.addr == OFF_DIV_LOW;
    wire sel_high = req.addr == OFF_DIV_HIGH;
    wire sel_rx = req.addr == OFF_RX_DATA;
    wire wr_ctl = req.wr & sel_ctl;
    wire wr_low = req.wr & sel_low;
    wire wr_high = req.wr & sel_high;
    wire rd_rx = req.rd & sel_rx;

    wire receiver_idle_flag = ~receiver_busy;
    wire [DATA_W-1:0] ctl_view = {receive_irq_flag, receiver_idle_flag, 1'b0,
        high_speed_select, divisor_16bit_select, sync_mode,
        wake_on_break_enable, autobaud_enable};
    wire [DATA_W-1:0] read_mux = sel_ctl ? ctl_view :
        sel_low ? divisor_low :
        sel_high ? divisor_high : receive_data_reg;
    wire [DATA_W-1:0] next_rdata = req.rd ? read_mux : REG_RESET;

    ////////////////////////////////////////////////////////////////////////////////
    // wake-on-break

    wire wake_active = wake_on_break_enable & ~sync_mode;
    wire wake_event = wake_active & fall;
    wire wake_end = wake_active & rise;

    // raw pin path: the only thing alive while the clocks are stopped
    assign wake_request = wake_active & ~receive_line;

    // normal reception parked while calibrating or watching for a break
    assign receiver_hold = autobaud_enable | wake_active;

    ////////////////////////////////////////////////////////////////////////////////
    // autobaud sequencer

    wire state_measure = state == ST_MEASURE;
    wire fast_sel = divisor_16bit_select & high_speed_select;
    wire slow_sel = ~divisor_16bit_select & ~high_speed_select;
    // base clock over eight: osc/64, /16, /4 become /512, /128, /32
    wire [PRESCALE_W-1:0] div_sel = fast_sel ? DIV_FAST :
        slow_sel ? DIV_SLOW : DIV_MID;
    wire meas_tick = state_measure & run & (prescale >= div_sel);
    wire first_rise = (state == ST_WAIT_RISE) & rise & run;
    wire abd_done = state_measure & rise & run & (rises == RISE_LAST);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (autobaud_enable) begin
                    next_state = wake_active ? ST_AFTER_BREAK : ST_WAIT_START;
                end
            end
            ST_AFTER_BREAK: begin
                if (!wake_active) begin
                    next_state = ST_WAIT_START;
                end
            end
            ST_WAIT_START: begin
                if (fall && run) begin
                    next_state = ST_WAIT_RISE;
                end
            end
            ST_WAIT_RISE: begin
                if (first_rise) begin
                    next_state = ST_MEASURE;
                end
            end
            ST_MEASURE: begin
                if (abd_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // software abort drops the sequence
        if (!autobaud_enable) begin
            next_state = ST_IDLE;
        end
    end

    wire [COUNT_W-1:0] pair = {divisor_high, divisor_low};
    // counter owns the pair during calibration, software writes are lost
    wire [COUNT_W-1:0] next_pair = first_rise ? COUNT_START :
        meas_tick ? pair + COUNT_STEP : pair;
    wire [PRESCALE_W-1:0] next_prescale = (first_rise || meas_tick) ? '0 :
        (state_measure && run) ? prescale + PRESCALE_STEP : prescale;
    wire [2:0] next_rises = first_rise ? RISE_FIRST :
        (state_measure && rise && run) ? rises + RISE_STEP : rises;
    wire calibrating = first_rise | state_measure;

    ////////////////////////////////////////////////////////////////////////////////
    // control and flag updates

    wire next_autobaud = wr_ctl ? req.wdata[AUTOBAUD_EN_BIT] :
        (abd_done ? 1'b0 : autobaud_enable);
    wire next_wake = wr_ctl ? req.wdata[WAKE_EN_BIT] :
        (wake_end ? 1'b0 : wake_on_break_enable);
    wire rx_take = rx_byte_done & ~receiver_hold;
    wire irq_set = abd_done | wake_event | rx_take;
    // a set in the same cycle as the clearing read wins
    wire next_irq = irq_set | (receive_irq_flag & ~rd_rx);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            autobaud_enable <= 1'b0;
            wake_on_break_enable <= 1'b0;
            sync_mode <= 1'b0;
            divisor_16bit_select <= 1'b0;
            high_speed_select <= 1'b0;
            receive_irq_flag <= 1'b0;
        end else begin
            autobaud_enable <= next_autobaud;
            wake_on_break_enable <= next_wake;
            receive_irq_flag <= next_irq;
            if (wr_ctl) begin
                sync_mode <= req.wdata[SYNC_MODE_BIT];
                divisor_16bit_select <= req.wdata[DIV16_BIT];
                high_speed_select <= req.wdata[HIGH_SPEED_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            divisor_low <= REG_RESET;
            divisor_high <= REG_RESET;
        end else if (calibrating) begin
            {divisor_high, divisor_low} <= next_pair;
        end else begin
            if (wr_low) begin
                divisor_low <= req.wdata;
            end
            if (wr_high) begin
                divisor_high <= req.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            prescale <= '0;
            rises <= '0;
        end else begin
            state <= next_state;
            prescale <= next_prescale;
            rises <= next_rises;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            receive_data_reg <= REG_RESET;
            rdata <= REG_RESET;
        end else begin
            if (rx_take) begin
                receive_data_reg <= rx_byte;
            end
            rdata <= next_rdata;
        end
    end

    assign baud_cfg = '{div16: divisor_16bit_select, high_speed: high_speed_select,
        divisor: pair};

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    count_start_a: assert property (first_rise |=> pair == COUNT_START && state_measure)
        else $error("calibration count did not start at one");

    abd_finish_a: assert property (abd_done && !wr_ctl
        |=> !autobaud_enable && receive_irq_flag && state == ST_IDLE)
        else $error("fifth rise did not end calibration");

    count_step_a: assert property (meas_tick |=> pair == $past(pair) + COUNT_STEP)
        else $error("divisor pair did not advance on tick");

    tick_spacing_a: assert property (meas_tick && fast_sel && !wr_ctl
        |=> !meas_tick [*8])
        else $error("autobaud clock ticks too fast");

    sleep_freeze_a: assert property (state_measure && sleep_mode
        |=> $stable(pair) && $stable(rises))
        else $error("counting went on in sleep");

    hold_drop_a: assert property (rx_byte_done && receiver_hold
        |=> $stable(receive_data_reg))
        else $error("receiver took a byte while held");

    wake_set_a: assert property (wake_event |=> receive_irq_flag)
        else $error("wake event did not set the flag");

    wake_clear_a: assert property (wake_end && !wr_ctl |=> !wake_on_break_enable)
        else $error("break end did not clear wake enable");

    flag_read_a: assert property (rd_rx && !irq_set |=> !receive_irq_flag)
        else $error("reading receive data left the flag set");

    sync_block_a: assert property (sync_mode |-> !wake_request && !wake_event)
        else $error("wake active in synchronous mode");

    break_first_a: assert property (state == ST_AFTER_BREAK && wake_active
        |=> !state_measure)
        else $error("measured before the break ended");

    // sequencer progress; a control write may abort, so these hold only while enabled
    start_fall_a: assert property (state == ST_WAIT_START && autobaud_enable
        && fall && run |=> state == ST_WAIT_RISE)
        else $error("start bit did not arm the count");

    start_sleep_a: assert property (state == ST_WAIT_START && autobaud_enable
        && sleep_mode |=> state == ST_WAIT_START)
        else $error("start bit taken in sleep");

    rise_wait_a: assert property (state == ST_WAIT_RISE && autobaud_enable
        && !first_rise |=> state == ST_WAIT_RISE)
        else $error("count started without a rise");

    first_setup_a: assert property (first_rise
        |=> prescale == '0 && rises == RISE_FIRST)
        else $error("first rise did not reset the prescaler");

    rise_count_a: assert property (state_measure && rise && run && !abd_done
        |=> rises == $past(rises) + RISE_STEP)
        else $error("rise not counted");

    measure_stay_a: assert property (state_measure && autobaud_enable
        && !abd_done |=> state_measure)
        else $error("measurement left early");

    abort_idle_a: assert property (!autobaud_enable |=> state == ST_IDLE)
        else $error("sequencer ran with autobaud off");

    pair_guard_a: assert property (state_measure && (wr_low || wr_high)
        && !meas_tick |=> $stable(pair))
        else $error("software write reached the counting pair");

    tick_mid_a: assert property (meas_tick && !fast_sel && !slow_sel
        && !wr_ctl |=> !meas_tick [*8])
        else $error("mid-rate autobaud clock too fast");

    tick_slow_a: assert property (meas_tick && slow_sel && !wr_ctl
        |=> !meas_tick [*8])
        else $error("slow autobaud clock too fast");

    done_keep_a: assert property (abd_done && !meas_tick
        |=> $stable(pair) && !state_measure)
        else $error("count moved after the fifth rise");

    break_end_a: assert property (wake_end && state == ST_AFTER_BREAK
        && autobaud_enable && !wr_ctl |=> !wake_active ##1 state == ST_WAIT_START)
        else $error("measurement not armed after the break");

    flag_hold_a: assert property (receive_irq_flag && !rd_rx
        |=> receive_irq_flag)
        else $error("flag dropped without a read");

    abd_done_c: cover property (abd_done);
    wake_event_c: cover property (wake_event ##[1:1000] wake_end);
    abd_after_break_c: cover property (state == ST_AFTER_BREAK ##[1:1000] first_rise);
    set_clear_c: cover property (irq_set && rd_rx);
    sleep_measure_c: cover property (state_measure && sleep_mode);

endmodule

// *** dv/lin_sender.sv ***
`timescale 1ns/10ps
module lin_sender (
    // clock
    input wire logic clk,
    // serial line, idles high between frames
    output logic line
);
    initial line = 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    // lsb first, one level per bit time, changed just after an edge
    task automatic shift(input logic [15:0] v, input int n, input int bt);
        for (int i = 0; i < n; i++) begin
            line <= v[i];
            repeat (bt) @(posedge clk);
        end
    endtask
    // start, eight data bits, stop
    task automatic send_byte(input logic [7:0] b, input int bt);
        shift({6'h0, 1'b1, b, 1'b0}, 10, bt);
    endtask
    // thirteen zero bit times, then a full stop bit as gap for start-up
    task automatic send_break(input int bt);
        shift(16'h2000, 14, bt);
    endtask
endmodule

// *** dv/uart_autobaud_and_break_wakeup_tb.sv ***
`timescale 1ns/10ps
module uart_autobaud_and_break_wakeup_tb;
    import uart_abd_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_t req = '0;
    logic [DATA_W-1:0] rdata;
    logic line;
    logic sleep_mode = 1'b0;
    logic receiver_busy = 1'b0;
    logic [DATA_W-1:0] rx_byte = 8'h00;
    logic rx_byte_done = 1'b0;
    logic receiver_hold;
    baud_cfg_t baud_cfg;
    logic wake_request;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'h0000_9e75;
    logic [7:0] last_rx = 8'h00;

    always #12.5 clk = ~clk;

    uart_autobaud_wake #(.CNT_W(COUNT_W)) DUT (
        .clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
        .receive_line(line), .sleep_mode(sleep_mode), .receiver_busy(receiver_busy),
        .rx_byte(rx_byte), .rx_byte_done(rx_byte_done), .receiver_hold(receiver_hold),
        .baud_cfg(baud_cfg), .wake_request(wake_request));
    lin_sender tx (.clk(clk), .line(line));

    ////////////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // odd bit times keep the fifth rise clear of a tick boundary
    function logic [15:0] exp_count(input logic d16, input logic hs, input int bt);
        int div;
        div = (d16 & hs) ? 32 : ((d16 ^ hs) ? 128 : 512);
        return 16'(1 + (8 * bt) / div);
    endfunction
    function logic [7:0] ctl(input logic [7:0] b);
        return b | (receiver_busy ? 8'h00 : 8'h40);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task print_verdict();
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask
    // data stand only in the cycle after the strobe
    task rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1;
        chk(rdata, exp);
    endtask
    task pulse_rx(input logic [7:0] b);
        @(posedge clk);
        rx_byte <= b;
        rx_byte_done <= 1'b1;
        @(posedge clk);
        rx_byte_done <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        logic [7:0] sel;
        int bt;
        logic [15:0] cnt;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rd(OFF_CONTROL, ctl(8'h00));
        rd(OFF_DIV_LOW, 8'h00);
        rd(OFF_DIV_HIGH, 8'h00);
        wr(OFF_CONTROL, 8'he0);
        rd(OFF_CONTROL, ctl(8'h00));
        // every select pair; the last one behind a break
        for (int i = 0; i < 4; i++) begin
            // receiver forced idle before arming wake, busy at random otherwise
            receiver_busy <= (i == 3) ? 1'b0 : 1'(rnd() >> 3);
            bt = 201 + 2 * int'(rnd() % 128);
            sel = {3'h0, 1'(i >> 1), 1'(i), 3'h0};
            wr(OFF_CONTROL, sel | ((i == 3) ? 8'h03 : 8'h01));
            #1 chk(8'(receiver_hold), 8'h01);
            if (i == 3) begin
                tx.send_break(bt);
                repeat (2 * bt) @(posedge clk);
            end
            fork
                tx.send_byte(8'h55, bt);
                begin
                    // a write mid-measure must not disturb the count
                    repeat (4 * bt) @(posedge clk);
                    wr(OFF_DIV_LOW, 8'hff);
                end
            join
            cnt = exp_count(1'(i), 1'(i >> 1), bt);
            rd(OFF_CONTROL, ctl(sel | 8'h80));
            rd(OFF_DIV_LOW, cnt[7:0]);
            rd(OFF_DIV_HIGH, cnt[15:8]);
            chk(baud_cfg.divisor[7:0], cnt[7:0]);
            chk(baud_cfg.divisor[15:8], cnt[15:8]);
            chk(8'({baud_cfg.div16, baud_cfg.high_speed}), 8'({1'(i), 1'(i >> 1)}));
            rd(OFF_RX_DATA, last_rx);
            rd(OFF_CONTROL, ctl(sel));
        end
        // wake from sleep on a break
        sleep_mode <= 1'b1;
        wr(OFF_CONTROL, 8'h02);
        fork
            tx.send_break(bt);
            begin
                repeat (bt) @(posedge clk);
                chk(8'(wake_request), 8'h01);
                rd(OFF_CONTROL, ctl(8'h82));
            end
        join
        rd(OFF_CONTROL, ctl(8'h80));
        rd(OFF_RX_DATA, last_rx);
        // sleep freezes calibration, before the start bit and again mid-measure
        wr(OFF_CONTROL, 8'h19);
        tx.send_byte(8'h55, bt);
        rd(OFF_DIV_LOW, cnt[7:0]);
        sleep_mode <= 1'b0;
        fork
            tx.send_byte(8'h55, bt);
            begin
                repeat (4 * bt) @(posedge clk);
                sleep_mode <= 1'b1;
            end
        join
        rd(OFF_CONTROL, ctl(8'h19));
        wr(OFF_CONTROL, 8'h00);
        sleep_mode <= 1'b0;
        // synchronous mode has no wake function
        wr(OFF_CONTROL, 8'h06);
        fork
            tx.send_break(bt);
            begin
                repeat (bt) @(posedge clk);
                chk(8'(wake_request), 8'h00);
                chk(8'(receiver_hold), 8'h00);
            end
        join
        rd(OFF_CONTROL, ctl(8'h06));
        // held receiver drops its bytes, a free one delivers them
        wr(OFF_CONTROL, 8'h02);
        pulse_rx(8'(rnd()));
        rd(OFF_RX_DATA, last_rx);
        rd(OFF_CONTROL, ctl(8'h02));
        wr(OFF_CONTROL, 8'h00);
        last_rx = 8'(rnd());
        pulse_rx(last_rx);
        rd(OFF_CONTROL, ctl(8'h80));
        wr(OFF_RX_DATA, ~last_rx);
        rd(OFF_RX_DATA, last_rx);
        rd(OFF_CONTROL, ctl(8'h00));
        print_verdict();
    end
endmodule
